// ---- adc_control_registers.sv ----
// Purpose: converter control and result registers behind an AHB-Lite slave
// Assumes: trigger inputs and sleep are synchronous to clk
// Notes:   writes take no wait state, reads take one
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps

module adc_control_registers #(
    parameter int PIN_COUNT = 20,
    parameter int PERIODS   = adc_regs_pkg::CONV_PERIODS
) (
    // clock and reset
    input  logic                           clk,
    input  logic                           rst,
    // ahb-lite slave
    input  logic                           hsel,
    input  logic [31:0]                    haddr,
    input  logic [1:0]                     htrans,
    input  logic                           hwrite,
    input  logic [2:0]                     hsize,
    input  logic [31:0]                    hwdata,
    input  logic                           hready,
    output logic [31:0]                    hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // trigger sources, sleep and rc clock
    input  adc_regs_pkg::trigger_sources_t trig_in,
    input  logic                           sleep_mode,
    input  logic                           rc_tick,
    // analog core
    input  logic [9:0]                     analog_value,
    output logic                           converter_power,
    output logic [5:0]                     mux_channel,
    output logic                           mux_valid,
    output logic [1:0]                     vref_select,
    output logic                           vref_valid,
    output logic                           conv_busy,
    // interrupt
    output logic                           irq
);

    // ********************************************************
    // registers and bus state
    // ********************************************************
    logic [7:0]  ctrl_zero;
    logic [7:0]  ctrl_one;
    logic [7:0]  auto_trig;
    logic [15:0] result;
    logic [7:0]  status;
    logic [7:0]  mask;
    logic        wr_pend;
    logic        rd_wait;
    logic        bus_hit;
    logic [9:0]  bus_idx;
    logic [7:0]  read_byte;
    logic        accept;
    logic        wr_en;
    logic [7:0]  wbyte;

    logic        go;
    logic        on;
    logic        fmt;
    logic [3:0]  trig_code;
    logic        sel_level;
    logic        prev_level;
    logic        trig_rise;
    logic        res_read;
    logic        trig_event;
    logic        pending;
    logic        sw_go;
    logic        start_req;
    logic        abort;
    logic        eng_busy;
    logic        eng_done;
    logic [9:0]  eng_value;
    logic [7:0]  next_status;

    assign accept    = hsel && hready && htrans[1];
    assign wr_en     = wr_pend && bus_hit;
    assign wbyte     = hwdata[7:0];
    assign go        = ctrl_zero[adc_regs_pkg::GO_BIT];
    assign on        = ctrl_zero[adc_regs_pkg::ON_BIT];
    assign fmt       = ctrl_one[adc_regs_pkg::FMT_BIT];
    assign trig_code = auto_trig[3:0];

    // ********************************************************
    // bus slave
    // ********************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend   <= 1'b0;
            rd_wait   <= 1'b0;
            bus_hit   <= 1'b0;
            bus_idx   <= 10'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= accept && hwrite;
            rd_wait   <= accept && !hwrite;
            hreadyout <= !(accept && !hwrite);
            hresp     <= 1'b0;
            if (accept) begin
                bus_hit <= (haddr[31:12] == 20'h0_0000)
                           && (haddr[1:0] == 2'h0);
                bus_idx <= haddr[11:2];
            end
        end
    end

    always_comb begin
        case (bus_idx)
            adc_regs_pkg::IDX_RESULT_LOW:  read_byte = result[7:0]; // [R14]
            adc_regs_pkg::IDX_RESULT_HIGH: read_byte = result[15:8];
            adc_regs_pkg::IDX_CTRL_ZERO:   read_byte = ctrl_zero;
            adc_regs_pkg::IDX_CTRL_ONE:    read_byte = ctrl_one;
            adc_regs_pkg::IDX_AUTO_TRIG:   read_byte = auto_trig;
            adc_regs_pkg::IDX_STATUS:      read_byte = status;
            adc_regs_pkg::IDX_MASK:        read_byte = mask;
            default:                       read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_wait) begin
            hrdata <= bus_hit ? {24'h00_0000, read_byte} : 32'h0000_0000;
        end
    end

    // ********************************************************
    // trigger selection and sleep latch
    // ********************************************************
    always_comb begin
        case (trig_code)
            adc_regs_pkg::TRIG_PIN:      sel_level = trig_in.pin; // [R11]
            adc_regs_pkg::TRIG_TMR_ZERO:
                sel_level = trig_in.timer_zero_overflow;
            adc_regs_pkg::TRIG_TMR_ONE:
                sel_level = trig_in.timer_one_overflow;
            adc_regs_pkg::TRIG_TMR_TWO:
                sel_level = trig_in.timer_two_postscaled;
            adc_regs_pkg::TRIG_CCP_ONE:
                sel_level = trig_in.capture_compare_one_output; // [R12]
            adc_regs_pkg::TRIG_CCP_TWO:
                sel_level = trig_in.capture_compare_two_output;
            adc_regs_pkg::TRIG_PWM_3:
                sel_level = trig_in.pwm_unit_three_output;
            adc_regs_pkg::TRIG_PWM_4:
                sel_level = trig_in.pwm_unit_four_output;
            adc_regs_pkg::TRIG_IOC:      sel_level = trig_in.change_flag;
            default:                     sel_level = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= sel_level;
        end
    end

    assign trig_rise  = sel_level && !prev_level; // [R15]
    assign res_read   = accept && !hwrite
                        && (haddr[11:2] == adc_regs_pkg::IDX_RESULT_HIGH)
                        && (trig_code == adc_regs_pkg::TRIG_RES_READ); // [R13]
    assign trig_event = on && (trig_rise || res_read);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= 1'b0;
        end else if (!on) begin
            pending <= 1'b0;
        end else if (sleep_mode && trig_event) begin
            pending <= 1'b1; // [R17]
        end else if (start_req) begin
            pending <= 1'b0;
        end
    end

    // ********************************************************
    // start, abort and the go bit
    // ********************************************************
    assign sw_go     = wr_en && (bus_idx == adc_regs_pkg::IDX_CTRL_ZERO)
                       && wbyte[adc_regs_pkg::GO_BIT];
    assign start_req = on && !go && !sleep_mode
                       && (sw_go || trig_event || pending); // [R4] [R17]
    // software clearing go, turning off, or sleeping off the rc clock aborts
    assign abort     = go && ((wr_en && !sw_go
                       && (bus_idx == adc_regs_pkg::IDX_CTRL_ZERO))
                       || (sleep_mode && (adc_regs_pkg::clock_ratio(
                           ctrl_one[6:4]) != 7'd0)));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_zero <= adc_regs_pkg::CTRL_ZERO_RST;
        end else begin
            if (wr_en && bus_idx == adc_regs_pkg::IDX_CTRL_ZERO) begin
                ctrl_zero[7:2] <= wbyte[7:2]; // [R1]
                ctrl_zero[adc_regs_pkg::ON_BIT] <= wbyte[adc_regs_pkg::ON_BIT];
            end
            if (start_req) begin
                ctrl_zero[adc_regs_pkg::GO_BIT] <= 1'b1; // [R4] [R15]
            end else if (eng_done || abort || !on) begin
                ctrl_zero[adc_regs_pkg::GO_BIT] <= 1'b0; // [R5] [R16]
            end
        end
    end

    // ********************************************************
    // configuration registers
    // ********************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_one  <= adc_regs_pkg::CTRL_ONE_RST;
            auto_trig <= adc_regs_pkg::AUTO_TRIG_RST;
            mask      <= adc_regs_pkg::MASK_RST;
        end else if (wr_en) begin
            if (bus_idx == adc_regs_pkg::IDX_CTRL_ONE) begin
                ctrl_one <= wbyte & adc_regs_pkg::CTRL_ONE_WMASK; // [R18]
            end
            if (bus_idx == adc_regs_pkg::IDX_AUTO_TRIG) begin
                auto_trig <= wbyte & adc_regs_pkg::AUTO_TRIG_WMASK; // [R18]
            end
            if (bus_idx == adc_regs_pkg::IDX_MASK) begin
                mask <= wbyte & 8'h01;
            end
        end
    end

    // ********************************************************
    // conversion engine and result
    // ********************************************************
    conversion_engine #(
        .PERIODS      (PERIODS)
    ) u_engine (
        .clk          (clk),
        .rst          (rst),
        .enable       (on),
        .start        (start_req),
        .abort        (abort),
        .clock_sel    (ctrl_one[6:4]),
        .rc_tick      (rc_tick),
        .analog_value (analog_value),
        .busy         (eng_busy),
        .done         (eng_done),
        .value        (eng_value)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result <= adc_regs_pkg::RESULT_RST;
        end else if (eng_done) begin
            if (fmt) begin
                result <= {6'h00, eng_value}; // [R7] [R19] [R16]
            end else begin
                result <= {eng_value, 6'h00}; // [R8] [R19]
            end
        end else if (wr_en && bus_idx == adc_regs_pkg::IDX_RESULT_LOW) begin
            result[7:0] <= wbyte; // [R14]
        end else if (wr_en && bus_idx == adc_regs_pkg::IDX_RESULT_HIGH) begin
            result[15:8] <= wbyte;
        end
    end

    // ********************************************************
    // done flag and interrupt
    // ********************************************************
    always_comb begin
        next_status = status;
        if (wr_en && bus_idx == adc_regs_pkg::IDX_STATUS) begin
            next_status = status & ~wbyte;
        end
        if (eng_done) begin
            next_status[adc_regs_pkg::DONE_BIT] = 1'b1; // [R16]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= adc_regs_pkg::STATUS_RST;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & mask);
        end
    end

    // ********************************************************
    // analog side controls
    // ********************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_power <= 1'b0;
            mux_channel     <= 6'h00;
            mux_valid       <= 1'b0;
            vref_select     <= 2'h0;
            vref_valid      <= 1'b0;
            conv_busy       <= 1'b0;
        end else begin
            converter_power <= on; // [R6]
            mux_channel     <= ctrl_zero[7:2];
            mux_valid       <= on && adc_regs_pkg::channel_ok(
                ctrl_zero[7:2], PIN_COUNT); // [R1] [R2] [R3]
            vref_select     <= ctrl_one[1:0];
            vref_valid      <= on
                && (ctrl_one[1:0] != adc_regs_pkg::REF_RESERVED); // [R10]
            conv_busy       <= eng_busy;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    property p_go_while_busy; // [R4]
        @(posedge clk) disable iff (rst) eng_busy |-> go;
    endproperty
    a_go_while_busy: assert property (p_go_while_busy)
        else $error("go low during conversion");

    property p_done_clears_go; // [R5]
        @(posedge clk) disable iff (rst) eng_done && !start_req |=> !go;
    endproperty
    a_done_clears_go: assert property (p_done_clears_go)
        else $error("go not cleared at completion");

    property p_off_idle; // [R6]
        @(posedge clk) disable iff (rst) !on |=> !eng_busy && !go;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("converter busy while off");

    property p_right_just; // [R7]
        @(posedge clk) disable iff (rst)
            eng_done && fmt |=> result == {6'h00, $past(eng_value)};
    endproperty
    a_right_just: assert property (p_right_just)
        else $error("right-justified result wrong");

    property p_left_just; // [R8]
        @(posedge clk) disable iff (rst)
            eng_done && !fmt |=> result == {$past(eng_value), 6'h00};
    endproperty
    a_left_just: assert property (p_left_just)
        else $error("left-justified result wrong");

    property p_trigger_starts; // [R15]
        @(posedge clk) disable iff (rst)
            trig_rise && on && !go && !sleep_mode |=> go ##1 conv_busy;
    endproperty
    a_trigger_starts: assert property (p_trigger_starts)
        else $error("trigger edge did not start conversion");

    property p_done_flag; // [R16]
        @(posedge clk) disable iff (rst)
            eng_done |=> status[adc_regs_pkg::DONE_BIT]
                && (irq == $past(mask[0]));
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("done flag or interrupt missing");

    property p_sleep_held; // [R17]
        @(posedge clk) disable iff (rst)
            sleep_mode && trig_event && !go |=> !go && pending;
    endproperty
    a_sleep_held: assert property (p_sleep_held)
        else $error("trigger during sleep not held");

    property p_reserved_zero; // [R18]
        @(posedge clk) disable iff (rst)
            ctrl_one[3:2] == 2'h0 && auto_trig[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unimplemented bits not zero");

    property p_read_trigger; // [R13]
        @(posedge clk) disable iff (rst)
            res_read && on && !go && !sleep_mode |=> go;
    endproperty
    a_read_trigger: assert property (p_read_trigger)
        else $error("high byte read did not trigger");

endmodule : adc_control_registers

// ---- adc_regs_pkg.sv ----
// Purpose: shared constants, types and helpers of the converter control block
// Assumes: register index times four is the byte address on the bus
// Notes:   field positions, reset values and codes are named here once
//
// Contract
// (R1) channel field bits 7..2 picks port A lines 0,1,2,4,5; code 3 reserved
// (R2) codes 0x0D-0x0F port B only with 20 pins; 0x12-0x15 port C 14/20 pins
// (R3) code 0x1B selects ground, 0x1E reference buffer; others select nothing
// (R4) writing one to go starts conversion; go reads one while it runs
// (R5) hardware clears go when the conversion finishes
// (R6) converter_on enables the converter; off means its logic is held idle
// (R7) result_format one: right-justified, upper six high-byte bits zero
// (R8) result_format zero: left-justified, lower six low-byte bits zero
// (R9) clock select: divide by 2,8,32,4,16,64; codes 3 and 7 rc clock
// (R10) reference: 00 supply, 10 external pin, 11 fixed reference; 01 reserved
// (R11) trigger codes 0..4: none, pin, timer zero, timer one, timer two
// (R12) codes 5..9: capture one, two, pwm three, four, change flag
// (R13) with trigger code 0xD a read of the result high byte triggers
// (R14) result is readable and writable as low and high byte
// (R15) a rising edge of the selected trigger sets go
// (R16) completion clears go, sets the done flag and loads the result
// (R17) a trigger during sleep is held and starts after sleep ends
// (R18) unimplemented control bits ignore writes and read zero
// (R19) the 10-bit value is placed by result_format, rest zero-filled

package adc_regs_pkg;

    // ********************************************************
    // register indices
    // ********************************************************
    localparam logic [9:0] IDX_RESULT_LOW  = 10'h09B;
    localparam logic [9:0] IDX_RESULT_HIGH = 10'h09C;
    localparam logic [9:0] IDX_CTRL_ZERO   = 10'h09D;
    localparam logic [9:0] IDX_CTRL_ONE    = 10'h09E;
    localparam logic [9:0] IDX_AUTO_TRIG   = 10'h09F;
    localparam logic [9:0] IDX_STATUS      = 10'h0A0;
    localparam logic [9:0] IDX_MASK        = 10'h0A1;

    // ********************************************************
    // field positions, write masks, reset values
    // ********************************************************
    localparam int         ON_BIT          = 0;
    localparam int         GO_BIT          = 1;
    localparam int         CHAN_LSB        = 2;
    localparam int         FMT_BIT         = 7;
    localparam int         CSEL_LSB        = 4;
    localparam int         REF_LSB         = 0;
    localparam int         DONE_BIT        = 0;
    localparam logic [7:0] CTRL_ONE_WMASK  = 8'hF3;
    localparam logic [7:0] AUTO_TRIG_WMASK = 8'h0F;
    localparam logic [7:0] CTRL_ZERO_RST   = 8'h00;
    localparam logic [7:0] CTRL_ONE_RST    = 8'h00;
    localparam logic [7:0] AUTO_TRIG_RST   = 8'h00;
    localparam logic [15:0] RESULT_RST     = 16'h0000;
    localparam logic [7:0] STATUS_RST      = 8'h00;
    localparam logic [7:0] MASK_RST        = 8'h00;
    localparam logic [1:0] REF_RESERVED    = 2'h1;
    localparam int         CONV_PERIODS    = 11;

    // ********************************************************
    // trigger source codes
    // ********************************************************
    localparam logic [3:0] TRIG_NONE     = 4'h0;
    localparam logic [3:0] TRIG_PIN      = 4'h1;
    localparam logic [3:0] TRIG_TMR_ZERO = 4'h2;
    localparam logic [3:0] TRIG_TMR_ONE  = 4'h3;
    localparam logic [3:0] TRIG_TMR_TWO  = 4'h4;
    localparam logic [3:0] TRIG_CCP_ONE  = 4'h5;
    localparam logic [3:0] TRIG_CCP_TWO  = 4'h6;
    localparam logic [3:0] TRIG_PWM_3    = 4'h7;
    localparam logic [3:0] TRIG_PWM_4    = 4'h8;
    localparam logic [3:0] TRIG_IOC      = 4'h9;
    localparam logic [3:0] TRIG_RES_READ = 4'hD;

    typedef struct packed {
        logic pin;
        logic timer_zero_overflow;
        logic timer_one_overflow;
        logic timer_two_postscaled;
        logic capture_compare_one_output;
        logic capture_compare_two_output;
        logic pwm_unit_three_output;
        logic pwm_unit_four_output;
        logic change_flag;
    } trigger_sources_t;

    // divide ratio of the conversion clock, zero means rc clock
    function automatic logic [6:0] clock_ratio(input logic [2:0] sel);
        case (sel)
            3'h0:    clock_ratio = 7'd2;
            3'h1:    clock_ratio = 7'd8;
            3'h2:    clock_ratio = 7'd32;
            3'h4:    clock_ratio = 7'd4;
            3'h5:    clock_ratio = 7'd16;
            3'h6:    clock_ratio = 7'd64;
            default: clock_ratio = 7'd0;
        endcase
    endfunction : clock_ratio

    // channel code routes an input on a part with the given pin count
    function automatic logic channel_ok(input logic [5:0] code,
                                        input int pins);
        case (code)
            6'h00, 6'h01, 6'h02, 6'h04, 6'h05: channel_ok = 1'b1;
            6'h0D, 6'h0E, 6'h0F:               channel_ok = (pins >= 20);
            6'h12, 6'h13, 6'h14, 6'h15:        channel_ok = (pins >= 14);
            6'h1B, 6'h1E:                      channel_ok = 1'b1;
            default:                           channel_ok = 1'b0;
        endcase
    endfunction : channel_ok

endpackage : adc_regs_pkg

// ---- conversion_engine.sv ----
// Purpose: timing of one conversion in conversion clock periods
// Assumes: rc_tick is a one-cycle pulse per rc clock period
// Notes:   value is captured from the analog core at the last period
`timescale 1ns/1ps

module conversion_engine #(
    parameter int PERIODS = adc_regs_pkg::CONV_PERIODS
) (
    // clock and reset
    input  logic       clk,
    input  logic       rst,
    // control
    input  logic       enable,
    input  logic       start,
    input  logic       abort,
    input  logic [2:0] clock_sel,
    input  logic       rc_tick,
    input  logic [9:0] analog_value,
    // result
    output logic       busy,
    output logic       done,
    output logic [9:0] value
);

    logic [6:0] ratio;
    logic [6:0] div_count;
    logic [7:0] period_count;
    logic       tick;
    logic       last;
    logic       halt;

    assign ratio = adc_regs_pkg::clock_ratio(clock_sel);
    assign tick  = (ratio == 7'd0) ? rc_tick
                                   : (div_count == ratio - 7'd1); // [R9]
    assign last  = tick && (period_count == 8'(PERIODS - 1));
    assign halt  = !enable || abort; // [R6]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_count <= 7'd0;
        end else if (halt || !busy || tick) begin
            div_count <= 7'd0;
        end else begin
            div_count <= div_count + 7'd1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy         <= 1'b0;
            period_count <= 8'd0;
        end else if (halt) begin
            busy         <= 1'b0;
            period_count <= 8'd0;
        end else if (start && !busy) begin
            busy         <= 1'b1;
            period_count <= 8'd0;
        end else if (busy && last) begin
            busy         <= 1'b0;
            period_count <= 8'd0;
        end else if (busy && tick) begin
            period_count <= period_count + 8'd1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done  <= 1'b0;
            value <= 10'h000;
        end else begin
            done <= busy && last && !halt;
            if (busy && last && !halt) begin
                value <= analog_value;
            end
        end
    end

endmodule : conversion_engine

// ---- adc_control_registers_tb.sv ----
// Purpose: self-checking bench of the converter control registers
// Assumes: ahb-lite single word transfers, one cycle read wait state
// Notes:   short conversions through a two-period engine
`timescale 1ns/1ps

module adc_control_registers_tb;
    localparam logic [9:0] LO = adc_regs_pkg::IDX_RESULT_LOW;
    localparam logic [9:0] HI = adc_regs_pkg::IDX_RESULT_HIGH;
    localparam logic [9:0] C0 = adc_regs_pkg::IDX_CTRL_ZERO;
    localparam logic [9:0] C1 = adc_regs_pkg::IDX_CTRL_ONE;
    localparam logic [9:0] AT = adc_regs_pkg::IDX_AUTO_TRIG;
    localparam logic [9:0] ST = adc_regs_pkg::IDX_STATUS;
    localparam logic [9:0] MK = adc_regs_pkg::IDX_MASK;
    logic        clk = 1'b0, rst = 1'b1, hwrite = 1'b0;
    logic        rc_tick = 1'b0, sleep_mode = 1'b0;
    logic        hreadyout, hresp, converter_power, mux_valid, irq;
    logic        vref_valid, conv_busy;
    logic [5:0]  mux_channel;
    logic [1:0]  vref_select;
    logic [5:0]  outs;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [9:0]  analog_value = 10'h000;
    logic [7:0]  q;
    int          n_fail = 0, compares = 0, cyc = 0;
    adc_regs_pkg::trigger_sources_t trig_in = '0;

    adc_control_registers #(.PERIODS(2)) dut (.clk, .rst, .hsel(1'b1),
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .trig_in, .sleep_mode,
        .rc_tick, .analog_value, .converter_power, .mux_channel,
        .mux_valid, .vref_select, .vref_valid, .conv_busy, .irq);

    // registered outputs that ck looks at, by bit index
    assign outs = {hresp, conv_busy, vref_valid, irq, converter_power,
                   mux_valid};
    always #4 clk = ~clk;
    // rc clock pulse every fifth cycle
    always @(posedge clk) rc_tick <= (cyc % 5 == 0);

    // ****************************************************
    // bus cycles and comparisons
    // ****************************************************
    task xfer(input logic w, input logic [9:0] i, input logic [7:0] d,
              output logic [7:0] r);
        haddr  <= {20'h0_0000, i, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata[7:0];
    endtask : xfer
    task cmp(input string s, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : cmp
    task rc(input logic [9:0] i, input logic [7:0] e);
        xfer(1'b0, i, 8'h00, q);
        cmp($sformatf("reg %h", i), e, q);
    endtask : rc
    // outputs are registered after the write lands
    task ck(input string s, input logic e, input int b);
        repeat (2) @(negedge clk);
        cmp(s, {7'h00, e}, {7'h00, outs[b]});
        @(posedge clk);
    endtask : ck
    task wt;
        logic [7:0] g;
        g = 8'h02;
        for (int k = 0; k < 99 && g[1] !== 1'b0; k++) xfer(1'b0, C0, 8'h00, g);
    endtask : wt
    task end_of_test;
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test;
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 8; k++) rc(LO + 10'(k), 8'h00);
        xfer(1'b1, C1, 8'hFF, q);
        rc(C1, 8'hF3);
        cmp("ref", 8'h03, {6'h00, vref_select});
        xfer(1'b1, AT, 8'hFF, q);
        rc(AT, 8'h0F);
        xfer(1'b1, LO, 8'h5A, q);
        xfer(1'b1, HI, 8'hA5, q);
        rc(LO, 8'h5A);
        rc(HI, 8'hA5);
        xfer(1'b1, AT, 8'h00, q);
        xfer(1'b1, C0, 8'h0D, q);
        ck("valid", 1'b0, 0);
        xfer(1'b1, C0, 8'h6D, q);
        ck("valid", 1'b1, 0);
        cmp("chan", 8'h1B, {2'h0, mux_channel});
        xfer(1'b1, C0, 8'h00, q);
        ck("power", 1'b0, 1);
        analog_value <= 10'h2B6;
        xfer(1'b1, MK, 8'h01, q);
        xfer(1'b1, C1, 8'hE0, q);
        xfer(1'b1, C0, 8'h01, q);
        ck("vref", 1'b1, 3);
        xfer(1'b1, C0, 8'h03, q);
        rc(C0, 8'h03);
        ck("busy", 1'b1, 4);
        wt;
        rc(C0, 8'h01);
        ck("irq", 1'b1, 2);
        rc(LO, 8'hB6);
        rc(HI, 8'h02);
        rc(ST, 8'h01);
        xfer(1'b1, ST, 8'h01, q);
        ck("irq", 1'b0, 2);
        xfer(1'b1, MK, 8'h00, q);
        xfer(1'b1, C1, 8'h00, q);
        xfer(1'b1, C0, 8'h03, q);
        wt;
        ck("irq", 1'b0, 2);
        rc(LO, 8'h80);
        rc(HI, 8'hAD);
        xfer(1'b1, MK, 8'h01, q);
        ck("irq", 1'b1, 2);
        xfer(1'b1, ST, 8'h01, q);
        analog_value <= 10'h155;
        xfer(1'b1, AT, 8'h01, q);
        trig_in.pin <= 1'b1;
        repeat (3) @(posedge clk);
        wt;
        rc(HI, 8'h55);
        trig_in.pin <= 1'b0;
        analog_value <= 10'h3FF;
        xfer(1'b1, AT, 8'h0D, q);
        xfer(1'b0, HI, 8'h00, q);
        wt;
        rc(LO, 8'hC0);
        xfer(1'b1, C1, 8'h30, q);
        xfer(1'b1, AT, 8'h01, q);
        sleep_mode <= 1'b1;
        trig_in.pin <= 1'b1;
        analog_value <= 10'h0F0;
        repeat (3) @(posedge clk);
        rc(C0, 8'h01);
        sleep_mode <= 1'b0;
        wt;
        rc(HI, 8'h3C);
        ck("resp", 1'b0, 5);
        rc(10'h0A2, 8'h00);
        end_of_test;
    end
endmodule : adc_control_registers_tb
